// ==== hdl/ibsc_pkg.sv ====
// Package of constants and types for the boot and security control block.
package ibsc_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'hBF;
   localparam logic [7:0] UNLOCK_ADDR = 8'hC0;
   localparam logic [7:0] SEC_ADDR = 8'hC1;
   localparam logic [7:0] UNLOCK_CODE1 = 8'h87;
   localparam logic [7:0] UNLOCK_CODE2 = 8'h59;
   localparam logic [15:0] SEC_ROM_ADDR = 16'hFFFF;
   localparam int BIT_SWRST = 7;
   localparam int BIT_RES6 = 6;
   localparam int BIT_BANK = 5;
   localparam int BIT_AUX = 4;
   localparam int BIT_ONE = 3;
   localparam int BIT_RES2 = 2;
   localparam int BIT_BOOT = 1;
   localparam int BIT_PROG = 0;
   localparam int SEC_LOCK = 0;
   localparam int SEC_TBL = 1;
   localparam int SEC_ENC = 2;
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [2:0] SEC_RESET = 3'h7;
   localparam logic [7:0] ENC_KEY = 8'hA5;
   typedef enum logic [1:0] {
      UNL_IDLE = 2'b00,
      UNL_HALF = 2'b01,
      UNL_OPEN = 2'b10
   } ibsc_unlock_type;
endpackage : ibsc_pkg

// ==== hdl/ibsc_security.sv ====
// One-way security bits and the access gating that they steer.
`timescale 1ns/1ps
module ibsc_security
   import ibsc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic prog_mode,
   input wire logic sec_access,
   input wire logic sec_program,
   input wire logic [2:0] sec_wdata,
   input wire logic erase_all,
   input wire logic fetch_external,
   output logic [2:0] sec_bits,
   output logic rom_access_ok,
   output logic table_internal_ok,
   output logic encrypt_on
);
   logic [2:0] sec_ff;
   logic [2:0] nxt_sec;
   logic sec_open;

   // Access only in programming mode at the top loader address, never locked.
   assign sec_open = prog_mode & sec_access & sec_ff[SEC_LOCK];

   // Each bit may only fall; erase-all and reset are the only ways back to one.
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_bit
         always_comb begin
            nxt_sec[g] = sec_ff[g];
            if (erase_all) begin
               nxt_sec[g] = 1'b1;
            end else if (sec_open && sec_program && !sec_wdata[g]) begin
               nxt_sec[g] = 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sec_ff <= SEC_RESET;
      end else if (clk_en) begin
         sec_ff <= nxt_sec;
      end
   end

   assign sec_bits = sec_open ? sec_ff : 3'h0;
   assign rom_access_ok = sec_ff[SEC_LOCK];
   // Internal fetches always see internal code; external ones only if allowed.
   assign table_internal_ok = !fetch_external | sec_ff[SEC_TBL];
   assign encrypt_on = !sec_ff[SEC_ENC];
endmodule : ibsc_security

// ==== hdl/ibsc_top.sv ====
// Boot bank, unlock, soft reset and security control for the controller.
// How it works
// - Bits 7, 1 and 0 all set force a soft reset of the control registers, not the security bits.
// - Bit 5 is read-only, one while running from loader bank.
// - Bit 4 enables the auxiliary memory.
// - Control writes only take effect after unlock codes 87h then 59h.
// - Any other value written to unlock register closes write permission.
// - Writing 83h resets into the application bank at once, or at timer expiry when in idle.
// - Power-on reset without boot pins starts from the application bank.
// - Pin P4.3 low, or P2.7 and P2.6 both low, boots loader bank.
// - Programming-enable set enters programming mode at next idle wake-up.
// - Security bits only fall; erase-all or reset alone returns them to one.
// - Security register reachable only in programming mode at FFFFh.
// - Lock bit zero blocks ROM and security register access.
// - Inhibit zero keeps external code-table reads out of internal ROM.
// - Internal code-table reads reach both; inhibit one lifts all limits.
// - Encryption bit zero encodes port-0 data; only whole erase or reset clears it.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module ibsc_top
   import ibsc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [7:0] rdata,
   input wire logic boot_pin_p43,
   input wire logic boot_pin_p27,
   input wire logic boot_pin_p26,
   input wire logic idle_active,
   input wire logic idle_wakeup,
   input wire logic [15:0] rom_addr,
   input wire logic sec_program,
   input wire logic erase_all,
   input wire logic fetch_external,
   input wire logic [7:0] port0_data_in,
   output logic [7:0] port0_data_out,
   output logic soft_reset_request,
   output logic running_bank_flag,
   output logic aux_memory_enable,
   output logic prog_mode,
   output logic rom_access_ok,
   output logic table_internal_ok,
   output logic encrypt_on
);
   ibsc_unlock_type unl_ff;
   ibsc_unlock_type nxt_unl;
   logic [7:0] ctrl_ff;
   logic bank_ff;
   logic prog_ff;
   logic boot_done_ff;
   logic soft_rst_ff;
   logic [7:0] rdata_ff;
   logic [7:0] p0_ff;
   logic [2:0] sec_bits;
   logic ctrl_wr;
   logic unl_wr;
   logic reset_combo;

   assign ctrl_wr = wr_strobe && addr == CTRL_ADDR && unl_ff == UNL_OPEN;
   assign unl_wr = wr_strobe && addr == UNLOCK_ADDR;

   // The sequence must be back to back on the unlock register.
   always_comb begin
      nxt_unl = unl_ff;
      if (unl_wr) begin
         if (wdata == UNLOCK_CODE1) begin
            nxt_unl = UNL_HALF;
         end else if (wdata == UNLOCK_CODE2 && unl_ff == UNL_HALF) begin
            nxt_unl = UNL_OPEN;
         end else if (wdata == UNLOCK_CODE2 && unl_ff == UNL_OPEN) begin
            nxt_unl = UNL_OPEN;
         end else begin
            nxt_unl = UNL_IDLE;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         unl_ff <= UNL_IDLE;
      end else if (clk_en) begin
         if (soft_rst_ff) begin
            unl_ff <= UNL_IDLE;
         end else begin
            unl_ff <= nxt_unl;
         end
      end
   end

   // Bit 3 is kept at one in hardware so a careless write cannot clear it.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= CTRL_RESET;
      end else if (clk_en) begin
         if (soft_rst_ff) begin
            ctrl_ff <= CTRL_RESET;
         end else if (ctrl_wr) begin
            ctrl_ff <= (wdata & ~(8'h01 << BIT_BANK)) |
                       (8'h01 << BIT_ONE);
         end
      end
   end

   assign reset_combo = ctrl_ff[BIT_SWRST] & ctrl_ff[BIT_BOOT] &
                        ctrl_ff[BIT_PROG];

   // The reset fires when the timer wakes the core from idle, or at once when not idle, so the
   // idle window gives software its own delay before the restart.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         soft_rst_ff <= 1'b0;
      end else if (clk_en) begin
         // The request is one cycle long; the bits that raise it are
         // still set while it stands, so it must not feed itself.
         soft_rst_ff <= !soft_rst_ff && reset_combo &&
                        (idle_wakeup || !idle_active);
      end
   end

   assign soft_reset_request = soft_rst_ff;

   // Boot straps are sampled on the first enabled edge after release.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         boot_done_ff <= 1'b0;
      end else if (clk_en) begin
         if (soft_rst_ff) begin
            boot_done_ff <= 1'b1;
         end else begin
            boot_done_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bank_ff <= 1'b0;
      end else if (clk_en) begin
         if (soft_rst_ff) begin
            bank_ff <= 1'b0;
         end else if (!boot_done_ff) begin
            bank_ff <= !boot_pin_p43 || (!boot_pin_p27 && !boot_pin_p26);
         end else if (idle_wakeup && ctrl_ff[BIT_PROG]) begin
            bank_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prog_ff <= 1'b0;
      end else if (clk_en) begin
         if (soft_rst_ff) begin
            prog_ff <= 1'b0;
         end else if (idle_wakeup) begin
            prog_ff <= ctrl_ff[BIT_PROG];
         end
      end
   end

   assign prog_mode = prog_ff;
   assign running_bank_flag = bank_ff;
   assign aux_memory_enable = ctrl_ff[BIT_AUX];

   ibsc_security u_sec (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .prog_mode(prog_ff),
      .sec_access(rom_addr == SEC_ROM_ADDR),
      .sec_program(sec_program),
      .sec_wdata(wdata[2:0]),
      .erase_all(erase_all),
      .fetch_external(fetch_external),
      .sec_bits(sec_bits),
      .rom_access_ok(rom_access_ok),
      .table_internal_ok(table_internal_ok),
      .encrypt_on(encrypt_on)
   );

   // A fixed XOR key is a light scramble, not strong protection.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         p0_ff <= 8'h00;
      end else if (clk_en) begin
         p0_ff <= encrypt_on ? (port0_data_in ^ ENC_KEY) :
                  port0_data_in;
      end
   end

   assign port0_data_out = p0_ff;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 8'h00;
      end else if (clk_en) begin
         if (rd_strobe) begin
            case (addr)
               CTRL_ADDR: begin
                  rdata_ff <= {ctrl_ff[7:6], bank_ff, ctrl_ff[4:0]};
               end
               UNLOCK_ADDR: rdata_ff <= {6'h00, unl_ff};
               SEC_ADDR: rdata_ff <= {5'h00, sec_bits};
               default: rdata_ff <= 8'h00;
            endcase
         end else begin
            rdata_ff <= 8'h00;
         end
      end
   end

   assign rdata = rdata_ff;
endmodule : ibsc_top

// ==== testbench/ibsc_checker.sv ====
// Port checks for the boot and security control block.
`timescale 1ns/1ps
module ibsc_checker
   import ibsc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_strobe,
   input wire logic idle_wakeup,
   input wire logic [15:0] rom_addr,
   input wire logic sec_program,
   input wire logic erase_all,
   input wire logic fetch_external,
   input wire logic [7:0] port0_data_in,
   input wire logic [7:0] port0_data_out,
   input wire logic soft_reset_request,
   input wire logic running_bank_flag,
   input wire logic aux_memory_enable,
   input wire logic prog_mode,
   input wire logic rom_access_ok,
   input wire logic table_internal_ok,
   input wire logic encrypt_on
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_unl;
      (wr_strobe && addr == UNLOCK_ADDR && wdata == UNLOCK_CODE1) ##1
      (wr_strobe && addr == UNLOCK_ADDR && wdata == UNLOCK_CODE2);
   endsequence
   sequence s_cls;
      wr_strobe && addr == UNLOCK_ADDR && wdata != UNLOCK_CODE1 &&
      wdata != UNLOCK_CODE2;
   endsequence
   property p_open;
      s_unl ##1 (wr_strobe && addr == CTRL_ADDR && wdata[BIT_AUX])
      |=> aux_memory_enable;
   endproperty
   a_open: assert property (p_open) else $error("open");
   property p_shut;
      s_cls ##1 (wr_strobe && addr == CTRL_ADDR)
      |=> $stable(aux_memory_enable);
   endproperty
   a_shut: assert property (p_shut) else $error("shut");
   property p_pulse;
      soft_reset_request |=> !soft_reset_request && !aux_memory_enable
      && !running_bank_flag && !prog_mode;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
   property p_prog;
      $rose(prog_mode) |-> $past(idle_wakeup) && running_bank_flag;
   endproperty
   a_prog: assert property (p_prog) else $error("prog");
   property p_tbl;
      !fetch_external |-> table_internal_ok;
   endproperty
   a_tbl: assert property (p_tbl) else $error("table");
   property p_erase;
      erase_all |=> rom_access_ok && !encrypt_on;
   endproperty
   a_erase: assert property (p_erase) else $error("erase");
   property p_sec;
      sec_program && !erase_all && rom_addr != SEC_ROM_ADDR
      |=> $stable(rom_access_ok) && $stable(encrypt_on);
   endproperty
   a_sec: assert property (p_sec) else $error("sec");
   property p_enc;
      $past(resetn) && $past(clk_en) |->
      port0_data_out == ($past(port0_data_in) ^
      ($past(encrypt_on) ? ENC_KEY : 8'h00));
   endproperty
   a_enc: assert property (p_enc) else $error("enc");
endmodule : ibsc_checker
bind ibsc_top ibsc_checker i_chk (.*);

// ==== testbench/ibsc_tb_top.sv ====
// Self-checking bench for the boot and security control block.
`timescale 1ns/1ps
module ibsc_tb_top
   import ibsc_pkg::*;
;
   logic sys_clk = 0, resetn = 0, wr_strobe = 0, rd_strobe = 0;
   logic clk_en = 1;
   logic boot_pin_p43 = 1, boot_pin_p27 = 1, boot_pin_p26 = 1;
   logic idle_active = 0, idle_wakeup = 0, sec_program = 0, erase_all = 0;
   logic fetch_external = 0, soft_reset_request, running_bank_flag, prog_mode;
   logic aux_memory_enable, rom_access_ok, table_internal_ok, encrypt_on;
   logic [7:0] addr = 0, wdata = 0, port0_data_in = 0, rdata, port0_data_out;
   logic [7:0] m_ctrl, sw[5] = '{8'h05, 8'h03, 8'h07, 8'h06, 8'h07};
   logic [15:0] rom_addr = 0;
   logic [2:0] m_sec;
   int error_cnt = 0, checked = 0, cyc = 0, n, m_open, seed = 32'hEA14C271;
   ibsc_top i_dut (.sys_clk, .resetn, .clk_en, .addr, .wdata,
      .wr_strobe, .rd_strobe, .rdata, .boot_pin_p43, .boot_pin_p27,
      .boot_pin_p26, .idle_active, .idle_wakeup, .rom_addr, .sec_program,
      .erase_all, .fetch_external, .port0_data_in, .port0_data_out,
      .soft_reset_request, .running_bank_flag, .aux_memory_enable,
      .prog_mode, .rom_access_ok, .table_internal_ok, .encrypt_on);
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   // The whole run needs well under a thousand cycles.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_strobe <= 1;
   endtask : wr
   task automatic idle();
      @(posedge sys_clk);
      {wr_strobe, rd_strobe, idle_wakeup, sec_program, erase_all} <= 5'h00;
      @(negedge sys_clk);
   endtask : idle
   task automatic rd_chk(input logic [7:0] exp);
      @(posedge sys_clk);
      addr <= CTRL_ADDR;
      rd_strobe <= 1;
      idle();
      chk(rdata, exp);
   endtask : rd_chk
   // Readback is only open in programming mode at the top loader address.
   task automatic rd_sec();
      @(posedge sys_clk);
      addr <= SEC_ADDR;
      rd_strobe <= 1;
      idle();
      chk(rdata, m_sec[0] ? {5'h00, m_sec} : 8'h00);
   endtask : rd_sec
   task automatic wc(input logic [7:0] d);
      wr(CTRL_ADDR, d);
      if (m_open) m_ctrl = d & 8'hDF | 8'h08;
   endtask : wc
   task automatic unl();
      wr(UNLOCK_ADDR, UNLOCK_CODE1);
      wr(UNLOCK_ADDR, UNLOCK_CODE2);
      m_open = 1;
   endtask : unl
   task automatic wake();
      @(posedge sys_clk);
      idle_wakeup <= 1;
      idle();
   endtask : wake
   task automatic rst(input logic [2:0] pins);
      @(posedge sys_clk);
      resetn <= 0;
      {boot_pin_p43, boot_pin_p27, boot_pin_p26} <= pins;
      repeat (5) @(posedge sys_clk);
      resetn <= 1;
      idle();
      m_sec = 7;
      m_ctrl = 8'h08;
      m_open = 0;
   endtask : rst
   task automatic sp(input logic [15:0] a, input logic [7:0] w);
      @(posedge sys_clk);
      rom_addr <= a;
      wdata <= w;
      sec_program <= 1;
      idle();
      if (a == SEC_ROM_ADDR && m_sec[0]) m_sec = m_sec & w[2:0];
   endtask : sp
   task automatic look();
      logic [7:0] v;
      v = 8'($random(seed));
      for (int j = 0; j < 2; j++) begin
         @(posedge sys_clk);
         fetch_external <= j[0];
         port0_data_in <= v;
         @(negedge sys_clk);
         chk(table_internal_ok, !j[0] || m_sec[1]);
      end
      chk(port0_data_out, m_sec[2] ? v : v ^ ENC_KEY);
      chk(rom_access_ok, m_sec[0]);
      chk(encrypt_on, !m_sec[2]);
   endtask : look
   task automatic finish_test();
      $display("checked %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      for (int i = 0; i < 8; i++) begin
         rst(i[2:0]);
         chk(running_bank_flag, !i[2] || !i[1:0]);
      end
      rd_chk(8'h08);
      $display("boot straps done");
      wc(8'h18);
      idle();
      rd_chk(m_ctrl);
      unl();
      wc(8'h18);
      for (int i = 0; i < 4; i++) begin
         wc(8'($random(seed)) & 8'h32 | 8'h08);
         idle();
         rd_chk(m_ctrl);
         chk(aux_memory_enable, m_ctrl[BIT_AUX]);
      end
      wr(UNLOCK_ADDR, 8'h00);
      m_open = 0;
      wc(m_ctrl ^ 8'h10);
      wr(UNLOCK_ADDR, UNLOCK_CODE2);
      wr(UNLOCK_ADDR, UNLOCK_CODE1);
      wc(m_ctrl ^ 8'h10);
      idle();
      rd_chk(m_ctrl);
      unl();
      @(posedge sys_clk);
      clk_en <= 0;
      wr(CTRL_ADDR, m_ctrl ^ 8'h10);
      idle();
      @(posedge sys_clk);
      clk_en <= 1;
      rd_chk(m_ctrl);
      chk(aux_memory_enable, m_ctrl[BIT_AUX]);
      $display("unlock done");
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         idle_active <= i[0];
         unl();
         wc(8'h83);
         idle();
         if (i == 1) begin
            chk(soft_reset_request, 0);
            rd_chk(8'h8B);
            wake();
         end
         for (n = 0; n < 4 && soft_reset_request !== 1; n++) begin
            @(negedge sys_clk);
         end
         chk(n < 4, 1);
         idle();
         chk(running_bank_flag, 0);
         rd_chk(8'h08);
         m_open = 0;
         m_ctrl = 8'h08;
         wc(8'h18);
         idle();
         chk(aux_memory_enable, 0);
      end
      $display("soft reset done");
      unl();
      wc(8'h09);
      idle();
      wake();
      chk(prog_mode, 1);
      chk(running_bank_flag, 1);
      sp(16'hFFFE, 8'h00);
      look();
      for (int k = 0; k < 5; k++) begin
         sp(SEC_ROM_ADDR, sw[k]);
         look();
         rd_sec();
      end
      @(posedge sys_clk);
      erase_all <= 1;
      idle();
      m_sec = 7;
      look();
      rd_sec();
      $display("security done");
      finish_test();
   end
endmodule : ibsc_tb_top
